// >>> shared/srap_map.vh
// Constants for the serial register access port: opcodes, map, layouts, timing
//
// Function
// - Inbound frame is 24 bits MSB first: 2 opcode, 6 address, 16 payload.
// - Opcode 00 write, 01 read, 10 read-and-clear, 11 device information read.
// - Write replaces writable register and returns its earlier content.
// - Read returns register content, ignores payload, changes nothing.
// - Burst read returns successive registers within one chip-select period.
// - Read-and-clear clears status bits where payload holds one, returns content.
// - Two 64-word spaces: opcodes 00-10 application, 11 device information.
// - Device information space is read-only fixed data.
// - Opcode 11 at address 3F returns every control register except retained register 7 to default.
// - Opcode 10 at address 3F clears every status register.
// - Retained register 7 survives reset-all; only power-on reset restores it.
// - Serial input sampled on rising serial clock edges.
// - Serial output changes after falling serial clock edges.
// - Output driven while chip select low, released when it rises.
// - Reply is status byte from frame start, payload loaded at eighth rising edge.
// - Odd parity over whole frame; mismatch reported as frame error.
// - Clock count outside the lengths the opcode allows (24; read 24 plus 16s; info 16 plus 8s) rejects frame, error in next reply.
// - Burst loads next address after each payload length, wrapping after 3F.
`ifndef SRAP_MAP_VH
`define SRAP_MAP_VH

// ==========================================================
// Operation codes and special address
`define SRAP_OP_WRITE 2'h0
`define SRAP_OP_READ 2'h1
`define SRAP_OP_RDCLR 2'h2
`define SRAP_OP_INFO 2'h3
`define SRAP_ADR_ALL 6'h3F

// ==========================================================
// Application map: control block, retained register, status block
`define SRAP_CTRL_BASE 6'h00
`define SRAP_CTRL_RETAIN 3'h7
`define SRAP_STAT_BASE 6'h10
`define SRAP_CTRL_RST 16'h0000
`define SRAP_STAT_RST 16'h0000
`define SRAP_DATA_MASK 16'hFFFE

// ==========================================================
// Device information map
`define SRAP_INFO_MAKER 6'h00
`define SRAP_INFO_FAMILY 6'h01
`define SRAP_INFO_PART1 6'h02
`define SRAP_INFO_PART2 6'h03
`define SRAP_INFO_MODE 6'h10
`define SRAP_INFO_SUPV 6'h11
`define SRAP_INFO_GSBOPT 6'h3E
`define SRAP_MODE_VAL 8'hA1
`define SRAP_GSBOPT_VAL 8'h11

// ==========================================================
// Frame geometry and clock monitor
`define SRAP_CNT_ADR 10'h008
`define SRAP_CNT_INFO_MIN 10'h010
`define SRAP_CNT_FRAME 10'h018
`define SRAP_CNT_MAX 10'h3FF

// ==========================================================
// Status byte bit positions, the reset flag among them
`define SRAP_GSB_NOERR 7
`define SRAP_GSB_RST 6
`define SRAP_GSB_FERR 5
`define SRAP_GSB_FE 3
`define SRAP_GSB_DE 2
`define SRAP_GSB_GW 1

// ==========================================================
// Timing
`define SRAP_SYS_KHZ 40000
`define SRAP_CSN_TO_MS 20

`endif

// >>> design/srap_sync.v
// Two-stage synchroniser for pins arriving from outside the system clock
`timescale 1ns/1ps
module srap_sync #(
   parameter W = 1,
   parameter [W-1:0] RST = {W{1'b0}}  // Reset level of each bit, its pin's idle level
) (
   input wire sys_clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;

   // First stage feeds only the second stage
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST;
         sync_ff <= RST;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule

// >>> design/srap_port.v
// Serial register access port: frame engine, register file, device information
`timescale 1ns/1ps
`include "srap_map.vh"
module srap_port #(
   parameter [19:0] CSN_TO_CYC = `SRAP_CSN_TO_MS * `SRAP_SYS_KHZ,
   parameter [7:0] MAKER_ID = 8'h3C,  // Arbitrary value
   parameter [7:0] FAMILY_ID = 8'h7E,  // Arbitrary value
   parameter [7:0] PART_ID1 = 8'h92,  // Arbitrary value
   parameter [7:0] PART_ID2 = 8'hB6,  // Arbitrary value
   parameter [7:0] SUPV_KIND = 8'h0C  // Arbitrary value
) (
   input wire sys_clk,
   input wire rst_n,
   input wire csn_n,
   input wire sck,
   input wire sdi,
   output wire sdo_o,
   output wire sdo_oe,
   input wire fe_in,
   input wire de_in,
   input wire gw_in,
   input wire [63:0] stat_set,
   output wire [127:0] ctrl_out,
   output wire frame_error_flag
);
   // ==========================================================
   // Pin synchronisation and edge detection
   wire [2:0] pin_s;
   wire csn_s;
   wire sck_s;
   wire sdi_s;
   reg csn_d_ff;
   reg sck_d_ff;

   // Select resets to its idle high level: a zero there would look like a
   // select fall and then a rejected frame end straight after reset
   srap_sync #(.W(3), .RST(3'h4)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d({csn_n, sck, sdi}),
      .q(pin_s)
   );
   assign csn_s = pin_s[2];
   assign sck_s = pin_s[1];
   assign sdi_s = pin_s[0];

   // Delayed copies of synchronised levels for edge finding
   // Their reset levels equal the pins' idle levels, so no false edge follows reset
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         csn_d_ff <= 1'b1;
         sck_d_ff <= 1'b0;
      end else begin
         csn_d_ff <= csn_s;
         sck_d_ff <= sck_s;
      end
   end

   wire frm_start = csn_d_ff & ~csn_s;
   wire frm_end = ~csn_d_ff & csn_s;
   wire in_frame = ~csn_s & ~csn_d_ff;
   wire sck_rise = in_frame & sck_s & ~sck_d_ff;
   wire sck_fall = in_frame & ~sck_s & sck_d_ff;

   // ==========================================================
   // Frame state
   // Cleared at every select fall, so no frame inherits the last one's count
   reg [23:0] in_ff;
   reg [23:0] out_ff;
   reg [9:0] rcnt_ff;
   reg [1:0] op_ff;
   reg [5:0] adr_ff;
   reg [7:0] gsb_ff;
   reg par_ok_ff;
   reg to_ff;
   reg [19:0] to_cnt_ff;
   reg rstb_ff;
   reg ferr_ff;
   reg [15:0] ctrl_ff [0:7];
   reg [15:0] stat_ff [0:3];

   wire [9:0] nxt_rcnt = (rcnt_ff == `SRAP_CNT_MAX) ? rcnt_ff : rcnt_ff + 10'h001;
   // Opcode and address as they stand at the eighth rising edge
   wire [1:0] cur_op = in_ff[6:5];
   wire [5:0] cur_adr = {in_ff[4:0], sdi_s};
   wire adr_load = sck_rise & (nxt_rcnt == `SRAP_CNT_ADR);
   // Burst reload after each further payload length
   wire burst_load = sck_rise & (op_ff == `SRAP_OP_READ) & (nxt_rcnt >= `SRAP_CNT_FRAME)
      & (nxt_rcnt[3:0] == 4'h8);
   wire [5:0] nxt_adr = adr_ff + 6'h01;  // Wraps after 3F

   // ==========================================================
   // Read data selection for application and information spaces
   // Block bases as parameters, so that their upper bits can be selected
   localparam [5:0] CTRL_BASE = `SRAP_CTRL_BASE;
   localparam [5:0] STAT_BASE = `SRAP_STAT_BASE;

   function [15:0] app_rd;
      input [5:0] a;
      begin
         app_rd = 16'h0000;
         if (a[5:3] == CTRL_BASE[5:3])
            app_rd = ctrl_ff[a[2:0]];
         else if (a[5:2] == STAT_BASE[5:2])
            app_rd = stat_ff[a[1:0]];
      end
   endfunction

   // Unused information addresses read as zero
   function [7:0] info_rd;
      input [5:0] a;
      begin
         case (a)
            `SRAP_INFO_MAKER: info_rd = MAKER_ID;
            `SRAP_INFO_FAMILY: info_rd = FAMILY_ID;
            `SRAP_INFO_PART1: info_rd = PART_ID1;
            `SRAP_INFO_PART2: info_rd = PART_ID2;
            `SRAP_INFO_MODE: info_rd = `SRAP_MODE_VAL;
            `SRAP_INFO_SUPV: info_rd = SUPV_KIND;
            `SRAP_INFO_GSBOPT: info_rd = `SRAP_GSBOPT_VAL;
            default: info_rd = 8'h00;
         endcase
      end
   endfunction

   // Payload word with odd parity in bit 0; first word also covers status byte
   // Burst words carry parity over their own sixteen bits only
   reg [15:0] ld_word;
   reg [15:0] ld_raw;
   always @* begin
      ld_raw = 16'h0000;
      if (adr_load) begin
         if (cur_op == `SRAP_OP_INFO)
            ld_raw = {info_rd(cur_adr), 8'h00};  // Info payload then zeros
         else
            ld_raw = app_rd(cur_adr) & `SRAP_DATA_MASK;
         ld_word = {ld_raw[15:1], ~(^gsb_ff ^ ^ld_raw[15:1])};
      end else begin
         ld_raw = app_rd(nxt_adr) & `SRAP_DATA_MASK;
         ld_word = {ld_raw[15:1], ~(^ld_raw[15:1])};
      end
   end

   // ==========================================================
   // Status byte as seen at frame start
   // Bits 4 and 0 are unused and held at zero
   wire [7:0] gsb_now;
   assign gsb_now[`SRAP_GSB_RST] = rstb_ff;
   assign gsb_now[`SRAP_GSB_FERR] = ferr_ff;
   assign gsb_now[4] = 1'b0;
   assign gsb_now[`SRAP_GSB_FE] = fe_in;
   assign gsb_now[`SRAP_GSB_DE] = de_in;
   assign gsb_now[`SRAP_GSB_GW] = gw_in;
   assign gsb_now[0] = 1'b0;
   assign gsb_now[`SRAP_GSB_NOERR] = ~(|gsb_now[6:0]);

   // ==========================================================
   // Shift engine: sample on rise, present on fall
   // Bit 23 is never loaded on a rise, so the pin moves only after a fall
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_ff <= 24'h000000;
         out_ff <= 24'h000000;
         rcnt_ff <= 10'h000;
         op_ff <= 2'h0;
         adr_ff <= 6'h00;
         gsb_ff <= 8'h00;
         par_ok_ff <= 1'b1;
      end else if (frm_start) begin
         in_ff <= 24'h000000;
         out_ff <= {gsb_now, 16'h0000};  // Status byte first
         gsb_ff <= gsb_now;
         rcnt_ff <= 10'h000;
         op_ff <= 2'h0;
         adr_ff <= 6'h00;
         par_ok_ff <= 1'b1;
      end else if (sck_rise) begin
         rcnt_ff <= nxt_rcnt;  // Clock monitor count
         if (rcnt_ff < `SRAP_CNT_FRAME)
            in_ff <= {in_ff[22:0], sdi_s};
         if (nxt_rcnt == `SRAP_CNT_FRAME)
            par_ok_ff <= ^{in_ff[22:0], sdi_s};  // Odd parity
         if (adr_load) begin
            op_ff <= cur_op;
            adr_ff <= cur_adr;
            out_ff[22:7] <= ld_word;  // Payload loaded here
         end else if (burst_load) begin
            adr_ff <= nxt_adr;
            out_ff[22:7] <= ld_word;
         end else if ((nxt_rcnt > `SRAP_CNT_FRAME) && (op_ff != `SRAP_OP_READ))
            out_ff[22:7] <= 16'h0000;  // Extra clocks of a non-read frame shift out zeros
      end else if (sck_fall) begin
         out_ff <= {out_ff[22:0], 1'b0};
      end
   end

   // Output follows flop; driven only inside chip select
   assign sdo_o = out_ff[23];
   assign sdo_oe = ~csn_s;

   // ==========================================================
   // Chip-select low timeout
   // The count halts once the flag is up, so a long burst cannot wrap it
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         to_cnt_ff <= 20'h00000;
         to_ff <= 1'b0;
      end else if (frm_start) begin
         to_cnt_ff <= 20'h00000;
         to_ff <= 1'b0;
      end else if (in_frame && !to_ff) begin
         to_cnt_ff <= to_cnt_ff + 20'h00001;
         if (to_cnt_ff >= CSN_TO_CYC - 20'h00001)
            to_ff <= 1'b1;  // Frame abandoned
      end
   end

   // ==========================================================
   // Frame acceptance at chip select rise
   // Info frames may stop at 16 clocks, before the parity bit arrives
   reg cnt_ok;
   always @* begin
      case (op_ff)
         `SRAP_OP_INFO: cnt_ok = (rcnt_ff >= `SRAP_CNT_INFO_MIN) && (rcnt_ff[2:0] == 3'h0);
         `SRAP_OP_READ: cnt_ok = (rcnt_ff >= `SRAP_CNT_FRAME) && (rcnt_ff[3:0] == 4'h8);
         default: cnt_ok = (rcnt_ff == `SRAP_CNT_FRAME);
      endcase
   end

   // Late abort and bad count or parity reject the whole frame
   wire frm_ok = cnt_ok & par_ok_ff & ~to_ff;
   wire commit = frm_end & frm_ok;
   wire [5:0] in_adr = in_ff[21:16];
   wire [15:0] in_pay = in_ff[15:0] & `SRAP_DATA_MASK;
   wire do_write = commit & (op_ff == `SRAP_OP_WRITE);
   wire do_clr = commit & (op_ff == `SRAP_OP_RDCLR);
   wire clr_all = do_clr & (in_adr == `SRAP_ADR_ALL);
   // Short info frames never fill the address field of in_ff; use the decoded one
   wire rst_ctrl = commit & (op_ff == `SRAP_OP_INFO) & (adr_ff == `SRAP_ADR_ALL);

   // Reset flag falls on the first good frame; error flag tracks last frame
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstb_ff <= 1'b1;
         ferr_ff <= 1'b0;
      end else if (frm_end) begin
         if (frm_ok)
            rstb_ff <= 1'b0;
         ferr_ff <= ~frm_ok;  // Shown in the next reply
      end
   end

   // ==========================================================
   // Control registers
   // Writes to the status block or to unused addresses are dropped
   integer i;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 8; i = i + 1)
            ctrl_ff[i] <= `SRAP_CTRL_RST;  // Power-on restores all
      end else begin
         for (i = 0; i < 8; i = i + 1) begin
            if (rst_ctrl && i != `SRAP_CTRL_RETAIN)
               ctrl_ff[i] <= `SRAP_CTRL_RST;  // Retained one is skipped
            else if (do_write && in_adr[5:3] == CTRL_BASE[5:3] && in_adr[2:0] == i)
               ctrl_ff[i] <= in_pay;
         end
      end
   end

   // ==========================================================
   // Status registers: a set in the clearing cycle wins
   // A flag raised in the cycle a clearing frame ends survives for the next read
   integer j;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (j = 0; j < 4; j = j + 1)
            stat_ff[j] <= `SRAP_STAT_RST;
      end else begin
         for (j = 0; j < 4; j = j + 1) begin
            if (clr_all)
               stat_ff[j] <= stat_set[16*j +: 16] & `SRAP_DATA_MASK;
            else if (do_clr && in_adr[5:2] == STAT_BASE[5:2] && in_adr[1:0] == j)
               stat_ff[j] <= ((stat_ff[j] & ~in_pay) | stat_set[16*j +: 16])
                  & `SRAP_DATA_MASK;
            else
               stat_ff[j] <= (stat_ff[j] | stat_set[16*j +: 16]) & `SRAP_DATA_MASK;
         end
      end
   end

   // ==========================================================
   // Outputs
   // Word i of the control block sits at bits 16*i and up
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_ctrl
         assign ctrl_out[16*g +: 16] = ctrl_ff[g];
      end
   endgenerate
   assign frame_error_flag = ferr_ff;
endmodule

// >>> tb/srap_props.sv
// Pin-level checker for the serial register access port
`timescale 1ns/1ps
module srap_props #(
   parameter [19:0] CSN_TO_CYC = 20'd800000
) (
   input wire sys_clk,
   input wire rst_n,
   input wire csn_n,
   input wire sck,
   input wire sdi,
   input wire sdo_o,
   input wire sdo_oe,
   input wire fe_in,
   input wire de_in,
   input wire gw_in,
   input wire [63:0] stat_set,
   input wire [127:0] ctrl_out,
   input wire frame_error_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Helpers: clock rises and low time of each frame, counted at the pins
   reg sck_ff, csn_ff;
   reg [9:0] rise_cnt_ff, last_cnt_ff;
   reg [19:0] low_cnt_ff;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_ff <= 1'b0;
         csn_ff <= 1'b1;
         rise_cnt_ff <= 10'h000;
         last_cnt_ff <= 10'h018;
         low_cnt_ff <= 20'h00000;
      end else begin
         sck_ff <= sck;
         csn_ff <= csn_n;
         // Saturate so a stuck select cannot wrap back into a legal window
         if (csn_n) low_cnt_ff <= 20'h00000;
         else if (low_cnt_ff != 20'hFFFFF) low_cnt_ff <= low_cnt_ff + 20'h00001;
         if (csn_ff && !csn_n) rise_cnt_ff <= 10'h000;
         else if (!csn_n && sck && !sck_ff) rise_cnt_ff <= rise_cnt_ff + 10'h001;
         if (csn_n && !csn_ff) last_cnt_ff <= rise_cnt_ff;
      end
   end
   // ==========================================
   // Steps of a frame as seen from the pins
   sequence s_sel; !csn_n [*4]; endsequence
   sequence s_desel; csn_n [*4]; endsequence
   sequence s_sck_high; sck [*2]; endsequence
   sequence s_frame_end; $rose(csn_n); endsequence
   property p_oe_on; s_sel |-> sdo_oe; endproperty
   property p_oe_off; s_desel |-> !sdo_oe; endproperty
   property p_sdo_hold; s_sck_high |-> $stable(sdo_o); endproperty
   property p_ctrl_quiet; $changed(ctrl_out) |-> csn_n && $past(csn_n); endproperty
   property p_ferr_quiet; $changed(frame_error_flag) |-> csn_n && $past(csn_n); endproperty
   property p_cnt_err;
      s_frame_end and (rise_cnt_ff[2:0] != 3'h0) |-> ##[1:6] frame_error_flag;
   endproperty
   property p_timeout;
      s_frame_end and (low_cnt_ff > CSN_TO_CYC + 20'd4) |-> ##[1:6] frame_error_flag;
   endproperty
   property p_ferr_clear;
      $fell(frame_error_flag) |-> last_cnt_ff >= 10'h010 && last_cnt_ff[2:0] == 3'h0;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("sdo not driven while selected");
   a_oe_off: assert property (p_oe_off) else $error("sdo driven while idle");
   a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved in high phase");
   a_ctrl_quiet: assert property (p_ctrl_quiet) else $error("control mid frame");
   a_ferr_quiet: assert property (p_ferr_quiet) else $error("error flag mid frame");
   a_cnt_err: assert property (p_cnt_err) else $error("bad count not flagged");
   a_timeout: assert property (p_timeout) else $error("timeout not flagged");
   a_ferr_clear: assert property (p_ferr_clear) else $error("flag cleared by bad frame");
endmodule

// >>> tb/srap_host.sv
// Host model: serial bus master sending 24-bit commands and collecting replies
`timescale 1ns/1ps
module srap_host (
   input wire sys_clk,
   input wire sdo_o,
   input wire sdo_oe,
   output logic csn_n,
   output logic sck,
   output logic sdi
);
   // Idle: deselected with the clock low
   initial begin
      csn_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end
   // ==========================================
   // One frame of n clocks at 200 ns; bad breaks the parity on purpose
   task automatic frame(input int n, input logic [22:0] hdr, input logic bad, input int hold,
                        output logic [63:0] rx);
      logic [23:0] w;
      int i;
      w = {hdr, ~^hdr ^ bad};
      rx = 64'h0;
      @(negedge sys_clk) csn_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      for (i = 0; i < n; i++) begin
         sdi = (i < 24) ? w[23 - i] : 1'b0;
         repeat (4) @(negedge sys_clk);
         sck = 1'b1;
         repeat (4) @(negedge sys_clk);
         // A released line is not trusted: take the inverse of the last bit
         rx = {rx[62:0], sdo_oe ? sdo_o : ~rx[0]};
         sck = 1'b0;
      end
      repeat (4 + hold) @(negedge sys_clk);
      csn_n = 1'b1;
      repeat (240) @(negedge sys_clk);
   endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the serial register access port
`timescale 1ns/1ps
`include "srap_map.vh"
module tb;
   localparam [19:0] TO_CYC = 20'd400;
   // Arbitrary identity values
   localparam [7:0] ID0 = 8'h2B, ID1 = 8'h6D, ID2 = 8'h9A, ID3 = 8'hC4, ID4 = 8'h18;
   localparam [97:0] ITAB = {6'h00, ID0, 6'h01, ID1, 6'h02, ID2, 6'h03, ID3,
      6'h10, `SRAP_MODE_VAL, 6'h11, ID4, 6'h3E, `SRAP_GSBOPT_VAL};
   logic sys_clk, rst_n, fe_in, de_in, gw_in;
   logic [63:0] stat_set, rx;
   wire csn_n, sck, sdi, sdo_o, sdo_oe, frame_error_flag;
   wire [127:0] ctrl_out;
   int n_mismatch, n_tests, cyc, i;
   srap_port #(.CSN_TO_CYC(TO_CYC), .MAKER_ID(ID0), .FAMILY_ID(ID1), .PART_ID1(ID2),
      .PART_ID2(ID3), .SUPV_KIND(ID4)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .csn_n(csn_n),
      .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .fe_in(fe_in), .de_in(de_in),
      .gw_in(gw_in), .stat_set(stat_set), .ctrl_out(ctrl_out),
      .frame_error_flag(frame_error_flag));
   srap_host host (.sys_clk(sys_clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .csn_n(csn_n),
      .sck(sck), .sdi(sdi));
   // ==========================================
   // Shared helpers
   function automatic logic [23:0] mk(input logic [7:0] s, input logic [15:0] d);
      mk = {s, d[15:1], ~^{s, d[15:1]}};
   endfunction
   task automatic ck(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xf(input logic [1:0] op, input logic [5:0] adr, input logic [15:0] pay);
      host.frame(24, {op, adr, pay[15:1]}, 1'b0, 0, rx);
   endtask
   task print_verdict;
      if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      xf(`SRAP_OP_READ, 6'h00, 16'h0000);
      ck(rx[23:0], mk(8'h40, 16'h0000));
      xf(`SRAP_OP_READ, 6'h00, 16'h0000);
      ck(rx[23:0], mk(8'h80, 16'h0000));
   endtask
   task automatic t_write;
      xf(`SRAP_OP_WRITE, 6'h01, 16'hA5A5);
      ck(rx[23:0], mk(8'h80, 16'h0000));
      ck({8'h00, ctrl_out[31:16]}, 24'h00A5A4);
      xf(`SRAP_OP_WRITE, 6'h01, 16'h5A5B);
      ck(rx[23:0], mk(8'h80, 16'hA5A4));
      xf(`SRAP_OP_READ, 6'h01, 16'hFFFF);
      ck(rx[23:0], mk(8'h80, 16'h5A5A));
      ck({8'h00, ctrl_out[31:16]}, 24'h005A5A);
   endtask
   task automatic t_err;
      host.frame(24, {`SRAP_OP_WRITE, 6'h02, 15'h0918}, 1'b1, 0, rx);
      ck({8'h00, ctrl_out[47:32]}, 24'h0);
      ck({23'h0, frame_error_flag}, 24'h1);
      host.frame(23, {`SRAP_OP_WRITE, 6'h02, 15'h0918}, 1'b0, 0, rx);
      ck({8'h00, ctrl_out[47:32]}, 24'h0);
      xf(`SRAP_OP_READ, 6'h02, 16'h0000);
      ck(rx[23:0], mk(8'h20, 16'h0000));
      ck({23'h0, frame_error_flag}, 24'h0);
   endtask
   task automatic t_timeout;
      host.frame(24, {`SRAP_OP_WRITE, 6'h03, 15'h0918}, 1'b0, 300, rx);
      ck({8'h00, ctrl_out[63:48]}, 24'h0);
      xf(`SRAP_OP_READ, 6'h03, 16'h0000);
      ck(rx[23:0], mk(8'h20, 16'h0000));
   endtask
   task automatic t_burst;
      xf(`SRAP_OP_WRITE, 6'h00, 16'h1110);
      host.frame(40, {`SRAP_OP_READ, `SRAP_ADR_ALL, 15'h0000}, 1'b0, 0, rx);
      ck(rx[39:16], mk(8'h80, 16'h0000));
      ck({8'h00, rx[15:0]}, 24'h001110);
   endtask
   task automatic t_clear;
      @(negedge sys_clk) stat_set = {32'h0, 16'h0006, 16'h00F0};
      @(negedge sys_clk) stat_set = 64'h0;
      xf(`SRAP_OP_READ, 6'h10, 16'h0000);
      ck(rx[23:0], mk(8'h80, 16'h00F0));
      xf(`SRAP_OP_RDCLR, 6'h10, 16'h0030);
      ck(rx[23:0], mk(8'h80, 16'h00F0));
      xf(`SRAP_OP_READ, 6'h10, 16'h0000);
      ck(rx[23:0], mk(8'h80, 16'h00C0));
      xf(`SRAP_OP_READ, 6'h11, 16'h0000);
      ck(rx[23:0], mk(8'h80, 16'h0006));
      xf(`SRAP_OP_RDCLR, `SRAP_ADR_ALL, 16'h0000);
      xf(`SRAP_OP_READ, 6'h11, 16'h0000);
      ck(rx[23:0], mk(8'h80, 16'h0000));
      xf(`SRAP_OP_READ, 6'h10, 16'h0000);
      ck(rx[23:0], mk(8'h80, 16'h0000));
   endtask
   task automatic t_rstall;
      xf(`SRAP_OP_WRITE, 6'h07, 16'h7776);
      xf(`SRAP_OP_INFO, `SRAP_ADR_ALL, 16'h0000);
      ck({8'h00, ctrl_out[15:0]}, 24'h0);
      ck({8'h00, ctrl_out[31:16]}, 24'h0);
      ck({8'h00, ctrl_out[127:112]}, 24'h007776);
   endtask
   task automatic t_info;
      for (i = 0; i < 7; i++) begin
         xf(`SRAP_OP_INFO, ITAB[14*i+8 +: 6], 16'h0000);
         ck(rx[23:0], mk(8'h80, {ITAB[14*i +: 8], 8'h00}));
      end
   endtask
   task automatic t_gsb;
      fe_in = 1'b1;
      gw_in = 1'b1;
      xf(`SRAP_OP_READ, 6'h00, 16'h0000);
      ck(rx[23:0], mk(8'h0A, 16'h0000));
      fe_in = 1'b0;
      gw_in = 1'b0;
      de_in = 1'b1;
      xf(`SRAP_OP_READ, 6'h00, 16'h0000);
      ck(rx[23:0], mk(8'h04, 16'h0000));
      de_in = 1'b0;
   endtask
   // Power-on reset in mid-run: the retained control word must return to default
   task automatic t_por;
      @(negedge sys_clk) rst_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (40) @(negedge sys_clk);
      ck({8'h00, ctrl_out[127:112]}, 24'h0);
      xf(`SRAP_OP_READ, 6'h07, 16'h0000);
      ck(rx[23:0], mk(8'h40, 16'h0000));
   endtask
   // ==========================================
   // Clock, hang guard and main sequence
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // About 30 frames of under 750 cycles each; the ceiling leaves ample room
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         print_verdict;
      end
   end
   initial begin
      rst_n = 1'b0;
      fe_in = 1'b0;
      de_in = 1'b0;
      gw_in = 1'b0;
      stat_set = 64'h0;
      n_mismatch = 0;
      n_tests = 0;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (40) @(negedge sys_clk);
      t_reset;
      t_write;
      t_err;
      t_timeout;
      t_burst;
      t_clear;
      t_rstall;
      t_info;
      t_gsb;
      t_por;
      print_verdict;
   end
endmodule
bind srap_port srap_props #(.CSN_TO_CYC(CSN_TO_CYC)) u_props (.sys_clk(sys_clk),
   .rst_n(rst_n), .csn_n(csn_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
   .fe_in(fe_in), .de_in(de_in), .gw_in(gw_in), .stat_set(stat_set), .ctrl_out(ctrl_out),
   .frame_error_flag(frame_error_flag));
